// >>> rtl/srfb_pkg.sv
/*
 * Shared constants and carrier types for the shadow RAM flash backup store.
 * Assumes one system clock and a synchronous active-high reset in every RTL user.
 */
package srfb_pkg;
  localparam int SHADOW_WORDS = 1024;
  localparam int MODULE_WORDS = 11000;
  localparam int SHADOW_STRINGS = 51;
  localparam int MODULE_STRINGS = 549;
  localparam int STR_CHARS = 40;
  localparam logic [13:0] STR_WORDS = 14'(STR_CHARS / 2);
  localparam logic [7:0] BACKUP_SEL = 8'hFC;
  localparam logic [15:0] BACKUP_ARG = 16'h0000;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [14:0] PROG_WORDS_BASE = 15'h1F40;
  localparam logic [14:0] PROG_WORDS_EXT = 15'h3E80;
  localparam logic [9:0] CNT_RESET = 10'h000;
  localparam logic [9:0] CNT_LAST = 10'(SHADOW_WORDS - 1);
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam int SYNC_STAGES = 2;

  // Processor command codes
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_STORE_WORD = 3'h1,
    OP_FETCH_WORD = 3'h2,
    OP_STORE_STRING = 3'h3,
    OP_FETCH_STRING = 3'h4,
    OP_SYSTEM_CONFIG = 3'h5
  } srfb_op_t;

  // addr: word address, string index, or selector in addr[7:0]
  // data: write data, or argument of a configuration command
  typedef struct packed {
    srfb_op_t op;
    logic [13:0] addr;
    logic [4:0] pair;
    logic [15:0] data;
  } srfb_cmd_t;

  typedef enum logic [1:0] {
    FL_READ = 2'h0,
    FL_ERASE = 2'h1,
    FL_PROGRAM = 2'h2
  } srfb_fl_op_t;

  typedef struct packed {
    srfb_fl_op_t op;
    logic [9:0] addr;
    logic [15:0] wdata;
  } srfb_flash_req_t;

  typedef struct packed {
    logic we;
    logic [13:0] addr;
    logic [15:0] wdata;
  } srfb_mod_req_t;

  // Controller states, Gray coded along load, idle, erase, copy
  typedef enum logic [2:0] {
    S_LOAD = 3'b000,
    S_IDLE = 3'b001,
    S_ERASE = 3'b011,
    S_COPY_RD = 3'b010,
    S_COPY = 3'b110,
    S_RST_GO = 3'b111,
    S_FETCH = 3'b101,
    S_MOD = 3'b100
  } srfb_state_t;
endpackage : srfb_pkg

// >>> rtl/srfb_sync.sv
/*
 * Two-stage level synchroniser for pins entering the system clock domain.
 * Assumes the input is a slow level; a pulse that no clock edge samples is lost.
 */
`timescale 1ns/1ns
`default_nettype none
module srfb_sync #(
  parameter int STAGES = 2
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic async_in,
  output logic sync_out
);
  import srfb_pkg::*;
  logic [STAGES-1:0] chain;
  logic [STAGES-1:0] next_chain;

  ////////////////////////////////////////////////////////////////////////
  // Shift chain; only the last stage is seen by logic
  always_comb begin
    next_chain = {chain[STAGES-2:0], async_in};
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      chain <= '0;
    end else begin
      chain <= next_chain;
    end
  end

  assign sync_out = chain[STAGES-1];
endmodule : srfb_sync
`default_nettype wire

// >>> rtl/srfb_top.sv
/*
 * Shadow RAM data store backed by a flash sector, with optional external
 * non-volatile module taking over as primary store.
 * Assumes a same-clock processor command port, a same-clock flash engine
 * answering each request with a one-cycle done, and asynchronous pins for
 * power-fail and module presence.
 */
`timescale 1ns/1ns
`default_nettype none
module srfb_top (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic cmd_valid_in,
  input wire srfb_pkg::srfb_cmd_t cmd_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  input wire logic sw_reset_req_in,
  input wire logic link_reset_req_in,
  output logic reset_go_out,
  input wire logic pfail_in,
  output logic pfail_irq_out,
  input wire logic module_present_in,
  output logic mod_valid_out,
  output srfb_pkg::srfb_mod_req_t mod_req_out,
  input wire logic [15:0] mod_rdata_in,
  input wire logic mod_ack_in,
  output logic flash_valid_out,
  output srfb_pkg::srfb_flash_req_t flash_req_out,
  input wire logic [15:0] flash_rdata_in,
  input wire logic flash_done_in,
  output logic load_done_out,
  output logic modified_out,
  output logic [14:0] prog_words_out
);
  import srfb_pkg::*;
  logic [15:0] ram [SHADOW_WORDS];
  logic [15:0] ram_rdata;
  logic [9:0] ram_raddr;
  logic ram_we;
  logic [9:0] ram_waddr;
  logic [15:0] ram_wdata;
  srfb_state_t state, next_state;
  logic [9:0] cnt, next_cnt;
  logic modified, next_modified;
  logic rst_pend, next_rst_pend;
  logic loaded, next_loaded;
  logic rsp_valid, next_rsp_valid;
  logic [15:0] rsp_data, next_rsp_data;
  logic reset_go, next_reset_go;
  srfb_mod_req_t mod_req, next_mod_req;
  logic pf_s, pf_q, pf_irq, next_pf_irq;
  logic present;
  logic [14:0] prog_words, next_prog_words;
  logic acc, is_str, is_store, is_fetch, is_backup, in_range;
  logic [13:0] eff_addr;
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  srfb_sync #(.STAGES(SYNC_STAGES)) u_sync_pf (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .async_in(pfail_in),
    .sync_out(pf_s)
  );
  srfb_sync #(.STAGES(SYNC_STAGES)) u_sync_mod (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .async_in(module_present_in),
    .sync_out(present)
  );
  ////////////////////////////////////////////////////////////////////////
  // Command decode and address range
  always_comb begin
    acc = cmd_valid_in & cmd_ready_out;
    is_str = (cmd_in.op == OP_STORE_STRING) || (cmd_in.op == OP_FETCH_STRING);
    is_store = (cmd_in.op == OP_STORE_WORD) || (cmd_in.op == OP_STORE_STRING);
    is_fetch = (cmd_in.op == OP_FETCH_WORD) || (cmd_in.op == OP_FETCH_STRING);
    is_backup = (cmd_in.op == OP_SYSTEM_CONFIG) && (cmd_in.addr[7:0] == BACKUP_SEL)
      && (cmd_in.data == BACKUP_ARG);
    eff_addr = is_str ? 14'(cmd_in.addr * STR_WORDS) + 14'(cmd_in.pair) : cmd_in.addr;
    // Out-of-range reads give zero, writes are dropped
    if (present) begin
      in_range = is_str ? (int'(cmd_in.addr) < MODULE_STRINGS && int'(cmd_in.pair) < STR_CHARS / 2)
        : (int'(cmd_in.addr) < MODULE_WORDS);
    end else begin
      in_range = is_str ? (int'(cmd_in.addr) < SHADOW_STRINGS && int'(cmd_in.pair) < STR_CHARS / 2)
        : (int'(cmd_in.addr) < SHADOW_WORDS);
    end
  end
  // Ready only once loaded and no reset backup is waiting
  assign cmd_ready_out = (state == S_IDLE) && !rst_pend;
  ////////////////////////////////////////////////////////////////////////
  // Controller next-state logic
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_modified = modified;
    next_rst_pend = rst_pend | sw_reset_req_in | link_reset_req_in;
    next_loaded = loaded;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_reset_go = 1'b0;
    next_mod_req = mod_req;
    ram_we = 1'b0;
    ram_waddr = cnt;
    ram_wdata = flash_rdata_in;
    ram_raddr = cnt;
    case (state)
      S_LOAD: begin
        // Whole sector copied in, erased words arrive as all ones
        if (flash_done_in) begin
          ram_we = 1'b1;
          next_cnt = cnt + 10'h001;
          if (cnt == CNT_LAST) begin
            next_state = S_IDLE;
            next_loaded = 1'b1;
            next_cnt = CNT_RESET;
          end
        end
      end
      S_IDLE: begin
        ram_raddr = eff_addr[9:0];
        if (rst_pend) begin
          // Backup only if dirty and flash is the store
          next_state = (modified && !present) ? S_ERASE : S_RST_GO;
        end else if (acc) begin
          if (is_backup) begin
            if (modified && !present) begin
              next_state = S_ERASE;
            end else begin
              next_rsp_valid = 1'b1;
            end
          end else if (present && in_range && (is_store || is_fetch)) begin
            next_mod_req = '{we: is_store, addr: eff_addr, wdata: cmd_in.data};
            next_state = S_MOD;
          end else if (is_fetch && in_range) begin
            next_state = S_FETCH;
          end else begin
            next_rsp_valid = 1'b1;
            next_rsp_data = DATA_RESET;
            if (is_store && in_range) begin
              ram_we = 1'b1;
              ram_waddr = eff_addr[9:0];
              ram_wdata = cmd_in.data;
              next_modified = 1'b1;
            end
          end
        end
      end
      S_FETCH: begin
        next_rsp_valid = 1'b1;
        next_rsp_data = ram_rdata;
        next_state = S_IDLE;
      end
      S_MOD: begin
        if (mod_ack_in) begin
          next_rsp_valid = 1'b1;
          next_rsp_data = mod_req.we ? DATA_RESET : mod_rdata_in;
          next_state = S_IDLE;
        end
      end
      S_ERASE: begin
        if (flash_done_in) begin
          next_state = S_COPY_RD;
          next_cnt = CNT_RESET;
        end
      end
      S_COPY_RD: begin
        next_state = S_COPY; // RAM read lands here
      end
      S_COPY: begin
        if (flash_done_in) begin
          next_cnt = cnt + 10'h001;
          next_state = S_COPY_RD;
          if (cnt == CNT_LAST) begin
            next_cnt = CNT_RESET;
            next_modified = 1'b0;
            next_state = rst_pend ? S_RST_GO : S_IDLE;
            next_rsp_valid = !rst_pend;
          end
        end
      end
      S_RST_GO: begin
        next_reset_go = 1'b1;
        next_rst_pend = sw_reset_req_in | link_reset_req_in; // Fresh request wins
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_LOAD;
      end
    endcase
  end
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state <= S_LOAD;
      cnt <= CNT_RESET;
      modified <= 1'b0;
      rst_pend <= 1'b0;
      loaded <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= DATA_RESET;
      reset_go <= 1'b0;
      mod_req <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      modified <= next_modified;
      rst_pend <= next_rst_pend;
      loaded <= next_loaded;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      reset_go <= next_reset_go;
      mod_req <= next_mod_req;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Shadow RAM; no reset, content comes from the flash load
  always_ff @(posedge sys_clk_in) begin
    if (ram_we) begin
      ram[ram_waddr] <= ram_wdata;
    end
    ram_rdata <= ram[ram_raddr];
  end
  ////////////////////////////////////////////////////////////////////////
  // Power-fail edge and capacity report
  always_comb begin
    next_pf_irq = pf_s & ~pf_q;
    next_prog_words = present ? PROG_WORDS_EXT : PROG_WORDS_BASE;
  end
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      pf_q <= 1'b0;
      pf_irq <= 1'b0;
      prog_words <= PROG_WORDS_BASE;
    end else begin
      pf_q <= pf_s;
      pf_irq <= next_pf_irq;
      prog_words <= next_prog_words;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Outputs; flash request held until its done pulse
  assign flash_valid_out = (state == S_LOAD) || (state == S_ERASE) || (state == S_COPY);
  assign flash_req_out = '{op: (state == S_LOAD) ? FL_READ
    : ((state == S_ERASE) ? FL_ERASE : FL_PROGRAM), addr: cnt, wdata: ram_rdata};
  assign mod_valid_out = (state == S_MOD);
  assign mod_req_out = mod_req;
  assign rsp_valid_out = rsp_valid;
  assign rsp_data_out = rsp_data;
  assign reset_go_out = reset_go;
  assign pfail_irq_out = pf_irq;
  assign load_done_out = loaded;
  assign modified_out = modified;
  assign prog_words_out = prog_words;
  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  a_fetch_timing: assert property (acc && is_fetch && in_range && !present
    |-> ##2 rsp_valid_out) else $error("shadow fetch answer late");
  a_backup_erase: assert property (acc && is_backup && modified && !present
    |=> state == S_ERASE && flash_req_out.op == FL_ERASE) else $error("backup not erasing");
  a_erase_then_copy: assert property (state == S_ERASE && flash_done_in
    |=> state == S_COPY_RD ##1 flash_req_out.op == FL_PROGRAM) else $error("copy not after erase");
  a_backup_skip: assert property (acc && is_backup && !modified
    |=> !flash_valid_out && rsp_valid_out) else $error("clean backup touched flash");
  a_reset_backup: assert property (state == S_IDLE && rst_pend && modified && !present
    |=> state == S_ERASE) else $error("reset without backup");
  a_load_first: assert property (!load_done_out |-> !cmd_ready_out)
    else $error("access before load");
  a_pfail_irq: assert property ($rose(pf_s) |=> pfail_irq_out ##1 !pfail_irq_out)
    else $error("power-fail handler not invoked");
  a_module_route: assert property (acc && present && in_range && is_store
    |=> mod_valid_out && mod_req_out.we && !flash_valid_out) else $error("module not used");
  a_prog_cap: assert property (##1 present |=> prog_words_out == PROG_WORDS_EXT)
    else $error("capacity wrong");
  a_modified_set: assert property (acc && is_store && in_range && !present
    |=> modified_out) else $error("write not flagged");

  c_backup_done: cover property (state == S_COPY && flash_done_in && cnt == CNT_LAST);
  c_reset_go: cover property (reset_go_out);
  c_module_read: cover property (state == S_MOD && mod_ack_in && !mod_req_out.we);
  c_skip: cover property (acc && is_backup && !modified);
endmodule : srfb_top
`default_nettype wire

// >>> verif/srfb_far_model.sv
/*
 * Flash sector and external module stand-ins facing the shadow store.
 * Assumes the design's clock and request structs; slow_in adds latency.
 */
`timescale 1ns/1ns
`default_nettype none
module srfb_far_model
  import srfb_pkg::*;
(
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic fl_valid_in,
  input wire srfb_flash_req_t fl_req_in,
  output logic [15:0] fl_rdata_out,
  output logic fl_done_out,
  input wire logic mod_valid_in,
  input wire srfb_mod_req_t mod_req_in,
  output logic [15:0] mod_rdata_out,
  output logic mod_ack_out
);
  logic [15:0] fl_mem [0:1023];
  logic [15:0] mod_mem [0:10999];
  logic [15:0] fl_rd = 16'h0000;
  logic [15:0] mod_rd = 16'h0000;
  logic [1:0] fl_wait = 2'h0;
  logic [1:0] mod_wait = 2'h0;
  int erase_cnt = 0;
  int prog_cnt = 0;
  int since_erase = 0;
  int order_bad = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Sector starts erased but never written
  initial begin
    fl_done_out = 1'b0;
    mod_ack_out = 1'b0;
    foreach (fl_mem[i]) fl_mem[i] = 16'hFFFF;
    foreach (mod_mem[i]) mod_mem[i] = 16'h0000;
  end
  // Released data lines show the inverse, so a stale read cannot pass
  assign fl_rdata_out = fl_done_out ? fl_rd : ~fl_rd;
  assign mod_rdata_out = mod_ack_out ? mod_rd : ~mod_rd;
  ////////////////////////////////////////////////////////////////////////////
  // Flash engine: program only clears bits, as real cells do
  always @(posedge clk_in) begin
    fl_done_out <= 1'b0;
    if (fl_valid_in && !fl_done_out) begin
      fl_wait <= fl_wait + 2'h1;
      if (fl_wait == {slow_in, slow_in}) begin
        fl_wait <= 2'h0;
        fl_done_out <= 1'b1;
        fl_rd <= fl_mem[fl_req_in.addr];
        if (fl_req_in.op == FL_ERASE) begin
          foreach (fl_mem[i]) fl_mem[i] = 16'hFFFF;
          erase_cnt++;
          since_erase = 0;
        end
        if (fl_req_in.op == FL_PROGRAM) begin
          fl_mem[fl_req_in.addr] = fl_mem[fl_req_in.addr] & fl_req_in.wdata;
          prog_cnt++;
          if (since_erase >= 1024) order_bad++;
          since_erase++;
        end
      end
    end
  end
  // Module answers after a wait set by slow_in, word access only
  always @(posedge clk_in) begin
    mod_ack_out <= 1'b0;
    if (mod_valid_in && !mod_ack_out) begin
      mod_wait <= mod_wait + 2'h1;
      if (mod_wait == {slow_in, slow_in}) begin
        mod_wait <= 2'h0;
        mod_ack_out <= 1'b1;
        mod_rd <= mod_mem[mod_req_in.addr];
        if (mod_req_in.we) mod_mem[mod_req_in.addr] = mod_req_in.wdata;
      end
    end
  end
endmodule : srfb_far_model
`default_nettype wire

// >>> verif/srfb_top_bench.sv
/*
 * Self-checking bench for the shadow store: queued answers, flash backups.
 * Assumes srfb_top and srfb_far_model; one 20 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module srfb_top_bench;
  import srfb_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  srfb_cmd_t cmd_in = '0;
  logic sw_reset_req_in = 1'b0;
  logic link_reset_req_in = 1'b0;
  logic pfail_in = 1'b0;
  logic module_present_in = 1'b0;
  logic slow = 1'b0;
  logic cmd_ready_out, rsp_valid_out, reset_go_out, pfail_irq_out;
  logic mod_valid_out, mod_ack_in, flash_valid_out, flash_done_in;
  logic load_done_out, modified_out;
  logic [15:0] rsp_data_out, mod_rdata_in, flash_rdata_in;
  logic [14:0] prog_words_out;
  srfb_mod_req_t mod_req_out;
  srfb_flash_req_t flash_req_out;
  logic [15:0] exp_q [$];
  logic [15:0] val;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 32'h5083;
  int n;

  always #25 sys_clk_in = ~sys_clk_in;

  srfb_top dut_u (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .sw_reset_req_in(sw_reset_req_in),
    .link_reset_req_in(link_reset_req_in), .reset_go_out(reset_go_out), .pfail_in(pfail_in),
    .pfail_irq_out(pfail_irq_out), .module_present_in(module_present_in),
    .mod_valid_out(mod_valid_out), .mod_req_out(mod_req_out), .mod_rdata_in(mod_rdata_in),
    .mod_ack_in(mod_ack_in), .flash_valid_out(flash_valid_out),
    .flash_req_out(flash_req_out), .flash_rdata_in(flash_rdata_in),
    .flash_done_in(flash_done_in), .load_done_out(load_done_out),
    .modified_out(modified_out), .prog_words_out(prog_words_out));

  srfb_far_model far_u (.clk_in(sys_clk_in), .slow_in(slow), .fl_valid_in(flash_valid_out),
    .fl_req_in(flash_req_out), .fl_rdata_out(flash_rdata_in), .fl_done_out(flash_done_in),
    .mod_valid_in(mod_valid_out), .mod_req_in(mod_req_out), .mod_rdata_out(mod_rdata_in),
    .mod_ack_out(mod_ack_in));
  ////////////////////////////////////////////////////////////////////////////
  task check(string name, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // Hang guard, well above the longest run of loads and backups
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      end_of_test();
    end
  end

  // Every answer is paired with the oldest queued note
  always @(negedge sys_clk_in) begin
    if (rsp_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected answer", 16'h0001, 16'h0000);
      else check("answer data", rsp_data_out, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // One outstanding command; valid held until the taking edge
  task send(srfb_op_t op, int addr, int pair, logic [15:0] data, logic [15:0] exp);
    exp_q.push_back(exp);
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_in <= '{op, 14'(addr), 5'(pair), data};
    n = 0;
    @(negedge sys_clk_in);
    while (cmd_ready_out !== 1'b1 && n < 20000) begin
      @(negedge sys_clk_in);
      n++;
    end
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'b0;
    while (exp_q.size() != 0 && n < 20000) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("answer wait", 16'(n >= 20000), 16'h0000);
  endtask : send

  task wait_load;
    n = 0;
    while (load_done_out !== 1'b1 && n < 20000) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("load done", 16'(load_done_out), 16'h0001);
  endtask : wait_load

  task reset_req(logic link);
    @(posedge sys_clk_in);
    sw_reset_req_in <= !link;
    link_reset_req_in <= link;
    @(posedge sys_clk_in);
    sw_reset_req_in <= 1'b0;
    link_reset_req_in <= 1'b0;
    n = 0;
    while (reset_go_out !== 1'b1 && n < 20000) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("reset go", 16'(reset_go_out), 16'h0001);
  endtask : reset_req
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    wait_load();
    check("program words", 16'(prog_words_out), 16'd8000);
    send(OP_FETCH_WORD, 0, 0, 16'h0000, 16'hFFFF);
    send(OP_FETCH_WORD, 1023, 0, 16'h0000, 16'hFFFF);
    send(OP_FETCH_WORD, 1024, 0, 16'h0000, 16'h0000);
    $display("test erased load finished");
    for (int i = 0; i < 4; i++) begin
      val = 16'($random(seed));
      send(OP_STORE_WORD, i * 341, 0, val, 16'h0000);
      send(OP_FETCH_WORD, i * 341, 0, 16'h0000, val);
    end
    send(OP_STORE_STRING, 50, 19, 16'h1234, 16'h0000);
    send(OP_FETCH_WORD, 1019, 0, 16'h0000, 16'h1234);
    check("modified", 16'(modified_out), 16'h0001);
    send(OP_SYSTEM_CONFIG, 251, 0, BACKUP_ARG, 16'h0000);
    send(OP_SYSTEM_CONFIG, 252, 0, 16'h0001, 16'h0000);
    check("erase count", 16'(far_u.erase_cnt), 16'h0000);
    send(OP_SYSTEM_CONFIG, 252, 0, BACKUP_ARG, 16'h0000);
    check("program count", 16'(far_u.prog_cnt), 16'd1024);
    check("sector word", far_u.fl_mem[1019], 16'h1234);
    check("modified", 16'(modified_out), 16'h0000);
    send(OP_SYSTEM_CONFIG, 252, 0, BACKUP_ARG, 16'h0000);
    check("erase count", 16'(far_u.erase_cnt), 16'h0001);
    $display("test backup command finished");
    slow <= 1'b1;
    send(OP_STORE_WORD, 7, 0, 16'h5AC3, 16'h0000);
    reset_req(1'b0);
    check("program count", 16'(far_u.prog_cnt), 16'd2048);
    check("sector word", far_u.fl_mem[7], 16'h5AC3);
    reset_req(1'b1);
    check("erase count", 16'(far_u.erase_cnt), 16'h0002);
    check("erase order", 16'(far_u.order_bad), 16'h0000);
    $display("test reset backup finished");
    @(posedge sys_clk_in);
    pfail_in <= 1'b1;
    n = 0;
    while (pfail_irq_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("power fail delay", 16'(n), 16'h0004);
    @(negedge sys_clk_in);
    check("power fail pulse", 16'(pfail_irq_out), 16'h0000);
    $display("test power fail finished");
    @(posedge sys_clk_in);
    srst_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(negedge sys_clk_in);
    wait_load();
    send(OP_FETCH_WORD, 7, 0, 16'h0000, 16'h5AC3);
    send(OP_FETCH_WORD, 1019, 0, 16'h0000, 16'h1234);
    $display("test reload finished");
    send(OP_STORE_WORD, 9, 0, 16'h00A5, 16'h0000);
    @(posedge sys_clk_in);
    module_present_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    check("program words", 16'(prog_words_out), 16'd16000);
    val = 16'($random(seed));
    send(OP_STORE_WORD, 10999, 0, val, 16'h0000);
    send(OP_FETCH_WORD, 10999, 0, 16'h0000, val);
    check("module word", far_u.mod_mem[10999], val);
    send(OP_STORE_STRING, 548, 19, 16'h0F0E, 16'h0000);
    send(OP_FETCH_WORD, 10979, 0, 16'h0000, 16'h0F0E);
    send(OP_FETCH_WORD, 11000, 0, 16'h0000, 16'h0000);
    send(OP_SYSTEM_CONFIG, 252, 0, BACKUP_ARG, 16'h0000);
    check("erase count", 16'(far_u.erase_cnt), 16'h0002);
    check("modified", 16'(modified_out), 16'h0001);
    $display("test module store finished");
    end_of_test();
  end
endmodule : srfb_top_bench
`default_nettype wire
